//--- pkg/tick_pkg.sv
// Package: constants, register map and carrier types for the tick lock and event trigger block
package tick_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CHANNELS = 12;
    localparam int SAMPLE_W = 10;
    localparam int FINE_W = 5;
    localparam int COARSE_W = 7;
    localparam int PHASE_W = 7;
    localparam int DIFF_W = 11;
    localparam int ACC_W = 16;
    localparam int IIR_FRAC = 6;
    localparam int IIR_SHIFT = 4;

    // ------------------------------------------------------------
    // Tick pattern and timing counts
    // ------------------------------------------------------------
    localparam logic [PHASE_W-1:0] TICK_PERIOD = 7'h46;
    localparam logic [PHASE_W-1:0] TICK_LOW = 7'h44;
    localparam logic [PHASE_W-1:0] TICK_HIGH = 7'h02;
    localparam logic [PHASE_W-1:0] PHASE_LAST = TICK_LOW + TICK_HIGH - 7'h01;
    localparam logic [PHASE_W-1:0] DIFF_PHASE = 7'h01;
    localparam logic [8:0] FRAME_HOLD = 9'h118;
    localparam logic [7:0] CAL_SETTLE = 8'h8C;
    localparam logic [7:0] CAL_DWELL = 8'hD2;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] REG_THRESHOLD = 8'h02;
    localparam logic [ADDR_W-1:0] REG_EVENTS = 8'h03;
    localparam logic [ADDR_W-1:0] REG_DELAY_BASE = 8'h10;
    localparam int CTRL_CAL_BIT = 0;
    localparam int CTRL_VOTE_LSB = 4;
    localparam int CTRL_SEL_LSB = 8;
    localparam int STATUS_BUSY_BIT = 12;
    localparam int DELAY_COARSE_LSB = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] VOTE_RESET = 4'h6;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [ACC_W-1:0] LOW_RESET = 16'h0000;
    localparam logic [ACC_W-1:0] HIGH_RESET = 16'hFFC0;
    localparam logic [ACC_W-1:0] MID_RESET = 16'h8000;
    localparam logic [DIFF_W-1:0] DIFF_FLOOR = 11'h400;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_bus_t;
    typedef logic [CHANNELS-1:0][FINE_W-1:0] fine_bus_t;
    typedef logic [CHANNELS-1:0][COARSE_W-1:0] coarse_bus_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic locked;
        logic header;
        logic [PHASE_W-1:0] phase;
        logic [DIFF_W-1:0] diff;
        logic diff_valid;
    } trk_status_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_SWEEP = 2'b01,
        CAL_ALIGN = 2'b11
    } cal_state_t;
endpackage

//--- design/tick_tracker.sv
// Module: one channel tracker locking a modulo-70 phase counter onto the tick marks
module tick_tracker (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Sample stream, decision level and frame busy flag
    input wire logic [tick_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic [tick_pkg::SAMPLE_W-1:0] threshold_in,
    input wire logic frame_busy_in,
    // Tracker status
    output tick_pkg::trk_status_t status_out
);
    import tick_pkg::*;

    typedef struct packed {
        trk_status_t st;
        logic prev1;
        logic prev2;
        logic [SAMPLE_W-1:0] hi_sample;
    } trk_state_t;

    trk_state_t s;
    trk_state_t next_s;
    logic level;
    logic tick_seen;

    always_comb begin
        level = (sample_in > threshold_in);
        // Two highs after a low: the ideal 68 low, 2 high pattern
        tick_seen = level && s.prev1 && !s.prev2;
        next_s = s;
        next_s.prev1 = level;
        next_s.prev2 = s.prev1;
        next_s.st.header = 1'b0;
        next_s.st.diff_valid = 1'b0;
        next_s.st.phase = (s.st.phase == PHASE_LAST) ? '0 : s.st.phase + 7'h01;
        // Alternate-cycle difference cancels per-cycle and paired glitches
        if (s.st.phase == PHASE_LAST) begin
            next_s.hi_sample = sample_in;
        end
        if (s.st.phase == DIFF_PHASE) begin
            next_s.st.diff = DIFF_W'({1'b0, s.hi_sample}) - DIFF_W'({1'b0, sample_in});
            next_s.st.diff_valid = 1'b1;
        end
        if (s.st.locked) begin
            // During a frame ticks are absent, so misses are not counted
            if (s.st.phase == PHASE_LAST && !tick_seen && !frame_busy_in) begin
                next_s.st.locked = 1'b0;
            end
            if (s.st.phase == '0 && level && s.prev1 && s.prev2 && !frame_busy_in) begin
                next_s.st.header = 1'b1;
            end
        end else begin
            if (level && !s.prev1) begin
                next_s.st.phase = PHASE_LAST;
            end
            if (s.st.phase == PHASE_LAST && tick_seen) begin
                next_s.st.locked = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign status_out = s.st;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_locked_wrap: assert property (s.st.locked && s.st.phase == PHASE_LAST |=> s.st.phase == '0)
        else $error("locked phase counter did not wrap after 70");
    a_lock_gain: assert property (!s.st.locked && s.st.phase == PHASE_LAST && tick_seen |=> s.st.locked)
        else $error("tracker failed to lock on aligned tick");
    a_header_once: assert property (s.st.header |=> !s.st.header)
        else $error("header pulse longer than one cycle");
endmodule

//--- design/level_threshold.sv
// Module: decision threshold from three IIR filters tracking low, high and midpoint levels
module level_threshold (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Sample and threshold
    input wire logic [tick_pkg::SAMPLE_W-1:0] sample_in,
    output logic [tick_pkg::SAMPLE_W-1:0] threshold_out
);
    import tick_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] low;
        logic [ACC_W-1:0] high;
        logic [ACC_W-1:0] mid;
    } thr_state_t;

    thr_state_t s;
    thr_state_t next_s;
    logic [SAMPLE_W:0] level_sum;

    // One pole low-pass step toward a ten-bit target
    function automatic logic [ACC_W-1:0] iir_step(input logic [ACC_W-1:0] acc, input logic [SAMPLE_W-1:0] x);
        logic signed [ACC_W:0] d;
        d = $signed({1'b0, x, {IIR_FRAC{1'b0}}}) - $signed({1'b0, acc});
        return ACC_W'($signed({1'b0, acc}) + (d >>> IIR_SHIFT));
    endfunction

    always_comb begin
        next_s = s;
        level_sum = {1'b0, s.low[ACC_W-1:IIR_FRAC]} + {1'b0, s.high[ACC_W-1:IIR_FRAC]};
        if (sample_in > s.mid[ACC_W-1:IIR_FRAC]) begin
            next_s.high = iir_step(s.high, sample_in);
        end else begin
            next_s.low = iir_step(s.low, sample_in);
        end
        next_s.mid = iir_step(s.mid, level_sum[SAMPLE_W:1]);
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '{low: LOW_RESET, high: HIGH_RESET, mid: MID_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign threshold_out = s.mid[ACC_W-1:IIR_FRAC];

    a_high_follows: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        sample_in > threshold_out && {sample_in, {IIR_FRAC{1'b0}}} > s.high |=> s.high >= $past(s.high))
        else $error("high level filter moved away from sample");
endmodule

//--- design/tick_lock_event_trigger.sv
// Module: twelve channel tick lock, threshold, coincidence trigger and delay control
//
// Functional notes
// - Twelve 10-bit sample streams, system clock domain.
// - Phase counter runs continuously, wraps at 70.
// - Locked when counter matches observed tick timing.
// - Out of lock, restart counter until aligned.
// - Threshold midway between low and high levels.
// - Three IIR filters make the threshold track.
// - One-cycle pulse per detected frame header.
// - Voter fires on enough same-cycle headers.
// - Trigger starts all channels together, in step.
// - Fine delay per fibre, 1/32 cycle steps.
// - Coarse delay per fibre, whole clock cycles.
// - Delays loaded by command or auto-calibration.
// - Tick pattern 68 low, 2 high, period 70.
module tick_lock_event_trigger (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Sample streams from the delay chips
    input wire tick_pkg::sample_bus_t raw_sample_in,
    // Register port
    input wire tick_pkg::reg_req_t reg_req_in,
    output logic [tick_pkg::DATA_W-1:0] rd_data_out,
    // Delay settings to the delay chips
    output tick_pkg::fine_bus_t fine_delay_out,
    output tick_pkg::coarse_bus_t coarse_delay_out,
    // Event and lock status
    output logic start_event_out,
    output logic [tick_pkg::CHANNELS-1:0] lock_out
);
    import tick_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cal_state_t cal;
        logic [FINE_W-1:0] cal_step;
        logic [7:0] dwell;
        fine_bus_t best_fine;
        logic [CHANNELS-1:0][DIFF_W-1:0] best_diff;
        fine_bus_t fine;
        coarse_bus_t coarse;
        logic [3:0] vote_min;
        logic [3:0] sel;
        logic [PHASE_W-1:0] ref_phase;
        logic [8:0] hold;
        logic start;
        logic [DATA_W-1:0] events;
        logic [CHANNELS-1:0] lock;
        logic [DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;
    trk_status_t [CHANNELS-1:0] trk;
    logic [SAMPLE_W-1:0] threshold;
    logic [CHANNELS-1:0] header_hits;
    logic [3:0] hit_count;
    logic frame_busy;
    logic [3:0] wr_idx;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] count_ones(input logic [CHANNELS-1:0] v);
        logic [3:0] c;
        c = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    function automatic logic is_delay_reg(input logic [ADDR_W-1:0] a);
        return (a >= REG_DELAY_BASE) && (a < REG_DELAY_BASE + ADDR_W'(CHANNELS));
    endfunction

    function automatic logic [3:0] delay_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - REG_DELAY_BASE;
        return d[3:0];
    endfunction

    // Cycles by which a channel's ticks trail the reference phase
    function automatic logic [COARSE_W-1:0] phase_gap(input logic [PHASE_W-1:0] ref_p,
                                                      input logic [PHASE_W-1:0] ch_p);
        logic [PHASE_W:0] g;
        g = {1'b0, ref_p} + {1'b0, TICK_PERIOD} - {1'b0, ch_p};
        if (g >= {1'b0, TICK_PERIOD}) begin
            g = g - {1'b0, TICK_PERIOD};
        end
        return g[COARSE_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // Channel trackers and threshold
    // ------------------------------------------------------------
    level_threshold u_threshold (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .sample_in(raw_sample_in[s.sel]),
        .threshold_out(threshold)
    );

    assign frame_busy = (s.hold != '0);

    for (genvar g = 0; g < CHANNELS; g++) begin : g_trk
        tick_tracker u_trk (
            .ref_clk_in(ref_clk_in),
            .reset_n_in(reset_n_in),
            .sample_in(raw_sample_in[g]),
            .threshold_in(threshold),
            .frame_busy_in(frame_busy),
            .status_out(trk[g])
        );
        assign header_hits[g] = trk[g].header;
    end

    assign hit_count = count_ones(header_hits);
    assign wr_idx = delay_index(reg_req_in.addr);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.rdata = '0;
        next_s.ref_phase = (s.ref_phase == PHASE_LAST) ? '0 : s.ref_phase + 7'h01;
        next_s.hold = frame_busy ? s.hold - 9'h001 : '0;
        for (int i = 0; i < CHANNELS; i++) begin
            next_s.lock[i] = trk[i].locked;
        end

        // Coincidence vote; a zero minimum disables triggering
        if (!frame_busy && s.vote_min != '0 && hit_count >= s.vote_min) begin
            next_s.start = 1'b1;
            // One hold for all channels keeps every tracker in step
            next_s.hold = FRAME_HOLD;
            next_s.events = s.events + 16'h0001;
        end

        // Register reads: data appear in the following cycle only
        if (reg_req_in.rd) begin
            if (reg_req_in.addr == REG_CONTROL) begin
                next_s.rdata = {4'h0, s.sel, s.vote_min, 3'h0, s.cal != CAL_IDLE};
            end else if (reg_req_in.addr == REG_STATUS) begin
                next_s.rdata = {3'h0, s.cal != CAL_IDLE, s.lock};
            end else if (reg_req_in.addr == REG_THRESHOLD) begin
                next_s.rdata = {6'h00, threshold};
            end else if (reg_req_in.addr == REG_EVENTS) begin
                next_s.rdata = s.events;
            end else if (is_delay_reg(reg_req_in.addr)) begin
                next_s.rdata = {1'b0, s.coarse[wr_idx], 3'h0, s.fine[wr_idx]};
            end
        end

        // Register writes
        if (reg_req_in.wr) begin
            if (reg_req_in.addr == REG_CONTROL) begin
                next_s.vote_min = reg_req_in.wdata[CTRL_VOTE_LSB +: 4];
                if (reg_req_in.wdata[CTRL_SEL_LSB +: 4] < 4'(CHANNELS)) begin
                    next_s.sel = reg_req_in.wdata[CTRL_SEL_LSB +: 4];
                end
            end else if (is_delay_reg(reg_req_in.addr) && s.cal == CAL_IDLE) begin
                // Manual loads are refused while a calibration run owns the delays
                next_s.fine[wr_idx] = reg_req_in.wdata[FINE_W-1:0];
                next_s.coarse[wr_idx] = reg_req_in.wdata[DELAY_COARSE_LSB +: COARSE_W];
            end
        end

        // Auto-calibration: sweep the fine delay, keep the steepest fall
        unique case (s.cal)
            CAL_IDLE: begin
                if (reg_req_in.wr && reg_req_in.addr == REG_CONTROL && reg_req_in.wdata[CTRL_CAL_BIT]) begin
                    next_s.cal = CAL_SWEEP;
                    next_s.cal_step = '0;
                    next_s.dwell = '0;
                    next_s.best_diff = {CHANNELS{DIFF_FLOOR}};
                    next_s.best_fine = '0;
                end
            end
            CAL_SWEEP: begin
                next_s.fine = {CHANNELS{s.cal_step}};
                for (int i = 0; i < CHANNELS; i++) begin
                    if (s.dwell >= CAL_SETTLE && trk[i].diff_valid &&
                        $signed(trk[i].diff) > $signed(s.best_diff[i])) begin
                        next_s.best_diff[i] = trk[i].diff;
                        next_s.best_fine[i] = s.cal_step;
                    end
                end
                if (s.dwell == CAL_DWELL) begin
                    next_s.dwell = '0;
                    next_s.cal_step = s.cal_step + 5'h01;
                    if (s.cal_step == '1) begin
                        next_s.cal = CAL_ALIGN;
                    end
                end else begin
                    next_s.dwell = s.dwell + 8'h01;
                end
            end
            CAL_ALIGN: begin
                next_s.fine = s.best_fine;
                for (int i = 0; i < CHANNELS; i++) begin
                    next_s.coarse[i] = phase_gap(s.ref_phase, trk[i].phase);
                end
                next_s.cal = CAL_IDLE;
            end
            // The fourth code is unused; fall back to idle if it ever appears
            default: begin
                next_s.cal = CAL_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '0;
            s.vote_min <= VOTE_RESET;
            s.sel <= SEL_RESET;
            s.best_diff <= {CHANNELS{DIFF_FLOOR}};
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_out = s.rdata;
    assign fine_delay_out = s.fine;
    assign coarse_delay_out = s.coarse;
    assign start_event_out = s.start;
    assign lock_out = s.lock;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_vote_fires: assert property (!frame_busy && s.vote_min != '0 && hit_count >= s.vote_min
        |=> start_event_out)
        else $error("trigger missing on enough coincident headers");
    a_vote_quiet: assert property (hit_count < s.vote_min || s.vote_min == '0 |=> !start_event_out)
        else $error("trigger raised below coincidence minimum");
    a_start_holds: assert property (start_event_out |-> s.hold == FRAME_HOLD ##1 !start_event_out [*8])
        else $error("trigger not a single pulse with full hold");
    a_manual_load: assert property (reg_req_in.wr && is_delay_reg(reg_req_in.addr) && s.cal == CAL_IDLE
        |=> fine_delay_out[$past(wr_idx)] == $past(reg_req_in.wdata[FINE_W-1:0]))
        else $error("manual fine delay not loaded");
    a_sweep_drive: assert property (s.cal == CAL_SWEEP |=> fine_delay_out == {CHANNELS{$past(s.cal_step)}})
        else $error("sweep step not driven to delay chips");
    a_cal_finish: assert property (s.cal == CAL_ALIGN
        |=> s.cal == CAL_IDLE && fine_delay_out == $past(s.best_fine))
        else $error("calibration did not apply its result");
    a_ref_wrap: assert property (s.ref_phase == PHASE_LAST
        |=> s.ref_phase == '0 ##69 s.ref_phase == PHASE_LAST)
        else $error("reference phase not periodic at 70");
    // Back-to-back reads are legal, so the data may only stay up if the previous cycle read again
    a_status_read: assert property (reg_req_in.rd && reg_req_in.addr == REG_STATUS
        |=> rd_data_out[CHANNELS-1:0] == $past(lock_out) ##1 (rd_data_out == '0 || $past(reg_req_in.rd)))
        else $error("status read does not show lock state");
endmodule

//--- sim/delay_chip_model.sv
// Far-side model: delay chips feeding per-fibre tick-mark sample streams
module delay_chip_model (
    // Clock
    input wire logic ref_clk_in,
    // Frame header request from the bench
    input wire logic hdr_arm_in,
    input wire logic [11:0] hdr_mask_in,
    // Delay settings from the block
    input wire tick_pkg::fine_bus_t fine_delay_in,
    input wire tick_pkg::coarse_bus_t coarse_delay_in,
    // Delayed samples
    output tick_pkg::sample_bus_t sample_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import tick_pkg::*;
    logic [11:0] hist [128];
    logic [6:0] cnt = 7'h00;
    logic armed = 1'b0;
    logic [11:0] bits;
    initial begin
        for (int i = 0; i < 128; i++) hist[i] = 12'h000;
    end
    // ------------------------------------------------------------
    // Pattern: 68 low, 2 high; a header adds a high at phase 0
    // ------------------------------------------------------------
    always_comb begin
        bits = 12'h000;
        if (cnt >= TICK_LOW) bits = 12'hFFF;
        else if (cnt == 7'h00 && armed) bits = hdr_mask_in;
    end
    always @(posedge ref_clk_in) begin
        cnt <= (cnt == TICK_PERIOD - 7'h01) ? 7'h00 : cnt + 7'h01;
        if (hdr_arm_in) armed <= 1'b1;
        else if (cnt == 7'h00) armed <= 1'b0;
        hist[0] <= bits;
        for (int i = 1; i < 128; i++) hist[i] <= hist[i-1];
    end
    // Fine delay only moves the sampling point inside a settled level, so levels ignore it
    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++)
            sample_out[ch] = hist[coarse_delay_in[ch]][ch] ? 10'h2BC : 10'h064;
    end
endmodule

//--- sim/tick_lock_event_trigger_tb.sv
// Testbench: lock, coincidence trigger, delay registers and calibration
`define CHK(nm, exp, got) begin checks_done++; if ((exp) !== (got)) begin fails++; \
    $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module tick_lock_event_trigger_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tick_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    reg_req_t req = '0;
    logic hdr_arm = 1'b0;
    logic [11:0] hdr_mask = 12'hFFF;
    sample_bus_t raw;
    logic [DATA_W-1:0] rd_data;
    fine_bus_t fine;
    coarse_bus_t coarse;
    logic start_event;
    logic [CHANNELS-1:0] locks;
    logic [DATA_W-1:0] v;
    int fails = 0;
    int checks_done = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    tick_lock_event_trigger DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .raw_sample_in(raw),
        .reg_req_in(req), .rd_data_out(rd_data), .fine_delay_out(fine), .coarse_delay_out(coarse),
        .start_event_out(start_event), .lock_out(locks));
    delay_chip_model far_end (.ref_clk_in(ref_clk_in), .hdr_arm_in(hdr_arm), .hdr_mask_in(hdr_mask),
        .fine_delay_in(fine), .coarse_delay_in(coarse), .sample_out(raw));
    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req.wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        req.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    // Spacing of 300 cycles keeps every shot clear of the trigger hold-off
    task automatic hdr_shot(input logic [11:0] m, input int exp);
        int hits;
        hits = 0;
        hdr_mask <= m;
        @(posedge ref_clk_in);
        hdr_arm <= 1'b1;
        @(posedge ref_clk_in);
        hdr_arm <= 1'b0;
        repeat (100) begin
            @(posedge ref_clk_in);
            #1 if (start_event === 1'b1) hits++;
        end
        `CHK("trigger pulses", exp, hits)
        repeat (300) @(posedge ref_clk_in);
    endtask
    task automatic wait_lock(input logic want, input int ch, input int lim);
        int n;
        n = 0;
        while (locks[ch] !== want && n < lim) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        // Reset is low from time zero, so outputs only settle at the first edge
        repeat (3) @(posedge ref_clk_in);
        #1;
        `CHK("lock in reset", 12'h000, locks)
        `CHK("coarse in reset", '0, coarse)
        @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        rd_reg(REG_CONTROL, v);
        `CHK("control reset", 16'h0060, v)
        rd_reg(8'h20, v);
        `CHK("unmapped read", 16'h0000, v)
        $display("test reset done");
    endtask
    task automatic test_lock;
        for (int ch = 0; ch < CHANNELS; ch++) wait_lock(1'b1, ch, 5000);
        `CHK("all locked", 12'hFFF, locks)
        // The high filter only moves on tick samples, so it needs many periods to settle
        repeat (2000) @(posedge ref_clk_in);
        rd_reg(REG_THRESHOLD, v);
        `CHK("threshold mid", 1'b1, (v[9:0] > 10'h12C && v[9:0] < 10'h1F4))
        rd_reg(REG_STATUS, v);
        `CHK("status lock", 12'hFFF, v[11:0])
        $display("test lock done");
    endtask
    task automatic test_vote;
        hdr_shot(12'hFFF, 1);
        rd_reg(REG_EVENTS, v);
        `CHK("event count", 16'h0001, v)
        wr_reg(REG_CONTROL, 16'h00C0);
        hdr_shot(12'h7FF, 0);
        hdr_shot(12'hFFF, 1);
        wr_reg(REG_CONTROL, 16'h0000);
        hdr_shot(12'hFFF, 0);
        wr_reg(REG_CONTROL, 16'h0060);
        hdr_shot(12'h03F, 1);
        rd_reg(REG_EVENTS, v);
        `CHK("event count", 16'h0003, v)
        $display("test vote done");
    endtask
    task automatic test_delay;
        wr_reg(8'h13, 16'h0311);
        #1;
        `CHK("fine ch3", 5'h11, fine[3])
        `CHK("coarse ch3", 7'h03, coarse[3])
        rd_reg(8'h13, v);
        `CHK("delay readback", 16'h0311, v)
        rd_reg(8'h1C, v);
        `CHK("delay past last", 16'h0000, v)
        wait_lock(1'b0, 3, 300);
        `CHK("lock lost ch3", 1'b0, locks[3])
        wait_lock(1'b1, 3, 5000);
        `CHK("lock again ch3", 1'b1, locks[3])
        $display("test delay done");
    endtask
    task automatic test_cal;
        int n;
        n = 0;
        wr_reg(REG_CONTROL, 16'h0061);
        rd_reg(REG_STATUS, v);
        `CHK("cal busy", 1'b1, v[STATUS_BUSY_BIT])
        while (v[STATUS_BUSY_BIT] !== 1'b0 && n < 5000) begin
            rd_reg(REG_STATUS, v);
            n++;
        end
        `CHK("cal done", 1'b0, v[STATUS_BUSY_BIT])
        $display("test cal done");
    endtask
    task automatic summarize;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        test_reset;
        test_lock;
        test_vote;
        test_delay;
        test_cal;
        summarize;
    end
    initial begin
        #600000;
        fails++;
        summarize;
    end
endmodule
